// file: shared/tsq_pkg.sv
// constants and types for the touch sense sequencer
package tsq_pkg;
  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_MODE = 5'h01;
  localparam logic [4:0] ADDR_TCR0 = 5'h02;
  localparam logic [4:0] ADDR_TCR1 = 5'h03;
  localparam logic [4:0] ADDR_TCR2 = 5'h04;
  localparam logic [4:0] ADDR_TCR3 = 5'h05;
  localparam logic [4:0] ADDR_CHAN = 5'h06;
  localparam logic [4:0] ADDR_SSTART = 5'h07;
  localparam logic [4:0] ADDR_RV0 = 5'h08;
  localparam logic [4:0] ADDR_RES1_LO = 5'h10;
  localparam logic [4:0] ADDR_RES1_HI = 5'h11;
  localparam logic [4:0] ADDR_PRIM_LO = 5'h12;
  localparam logic [4:0] ADDR_PRIM_HI = 5'h13;
  localparam logic [4:0] ADDR_STAT = 5'h14;
  localparam logic [4:0] ADDR_SEC = 5'h15;
  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL_START = 0;
  localparam int CTRL_SHORT = 1;
  localparam int CTRL_TRIG = 2;
  localparam int MODE_PRE = 0;
  localparam int MODE_RND = 1;
  localparam int MODE_CONST = 2;
  localparam int MODE_MJ = 4;
  localparam int TCR0_SKIP = 7;
  localparam int TCR1_DIS = 4;
  localparam int TCR2_SKIP = 3;
  localparam int TCR2_WAIT = 4;
  // ****************************************
  // reset values, trigger codes, timing
  // ****************************************
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [1:0] TRIG_SW = 2'h0;
  localparam logic [1:0] TRIG_TMR = 2'h2;
  localparam logic [1:0] TRIG_EXT = 2'h3;
  localparam logic [7:0] MAIN_FIXED_CYC = 8'h10;
  // ****************************************
  // status counter states, in status order
  // ****************************************
  typedef enum logic [4:0] {
    ST_IDLE, ST_LOAD, ST_CHARGE, ST_INIT,
    ST_S1_LOW, ST_S1_DIS, ST_S1_SET, ST_S1_DUM,
    ST_S1_WAIT, ST_S1_MAIN, ST_S1_JUDGE, ST_S1_POST,
    ST_DUM12, ST_S2_LOW, ST_S2_DIS, ST_S2_SET,
    ST_S2_DUM, ST_S2_WAIT, ST_S2_MAIN, ST_S2_JUDGE,
    ST_S2_POST, ST_XFER, ST_GAP, ST_CHAN,
    ST_WAIT_XFER, ST_IRQ
  } tsq_state_type;
endpackage

// file: rtl/tsq_sequencer.sv
// touch sense sequencer: status counter, counters, register port
//
// Overview of operation
// - status 0 idle, 1 loads settings
// - status 2 charges, then status 3
// - statuses 4/13 sense low, skippable
// - statuses 5/14 bias and sense low
// - statuses 6/15 settle, short switched on
// - dummy, then skippable pre-measure wait
// - statuses 9/18 sample, 10/19 judge
// - statuses 11/20 post period, short off
// - status 20 tests secondary for zero
// - status 21 requests data transfer
// - status 23 loops to next channel
// - status 24 waits transfer, 25 interrupts
// - pre enable gates pre into primary
// - pre uses single plain sample
// - random mode steps through sixteen values
// - majority field sets sample count
// - in random mode, fixed period is sixteen plus samples, sixteen alone at majority code 0
// - nine-bit primary, five-bit secondary counter
// - primary counts highs, secondary main only
// - capture result one and two
// - secondary counts down/up, capped at start
// - step change on low judgement(s)
// - results held in buffer registers
// - trigger field selects start source
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module tsq_sequencer (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // register port
  input wire logic [4:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // start sources
  input wire logic i_timer_trig,
  input wire logic i_ext_trig,
  // electrode pins
  input wire logic i_sense_in,
  output logic o_sense_out,
  output logic o_sense_oe,
  output logic o_bias_out,
  output logic o_bias_oe,
  output logic o_charge_out,
  output logic o_charge_oe,
  output logic o_bc_short,
  // transfer and interrupt
  output logic o_xfer_req,
  input wire logic i_xfer_done,
  output logic o_irq,
  // status view
  output logic [4:0] o_status,
  output logic [2:0] o_channel
);
  // ****************************************
  // declarations
  // ****************************************
  tsq_pkg::tsq_state_type state_q; // status counter
  tsq_pkg::tsq_state_type state_d; // next status
  logic start_q; // start bit
  logic [7:0] ctrl_q; // control byte
  logic [7:0] mode_q; // mode byte
  logic [7:0] tcr_q [0:3]; // timing bytes
  logic [7:0] sh_tcr_q [0:3]; // loaded timing
  logic [7:0] sh_mode_q; // loaded mode
  logic [2:0] range_q; // last channel
  logic [4:0] sstart_q; // secondary start
  logic [7:0] rv_q [0:7]; // random stores
  logic [7:0] cnt_q; // period counter
  logic [2:0] chan_q; // current channel
  logic [8:0] prim_q; // primary counter
  logic [4:0] sec_q; // secondary counter
  logic [8:0] res1_q; // result one
  logic [8:0] res2_q; // result two
  logic step2_q; // in step two
  logic pre_hi_q; // pre sample
  logic [3:0] hi_cnt_q; // highs in window
  logic [3:0] rv_idx_q; // random index
  logic xfer_pend_q; // transfer open
  logic short_q; // bias-charge short
  logic ext_prev_q; // last ext level
  logic go; // start condition
  logic [3:0] rv_cur; // current value
  logic [3:0] n_samp; // samples per main
  logic [7:0] win_lo; // window start
  logic [7:0] win_hi; // window end
  logic [7:0] main_len; // main period
  logic is_main; // in main state
  logic is_judge; // in judge state
  logic in_win; // sampling now
  logic main_hi; // majority high
  logic pre_cnt; // pre counts high
  logic both_low; // step change
  logic [8:0] prim_nx; // primary next
  logic [2:0] mj; // majority code
  logic pre_en; // pre enabled
  logic rnd_en; // random enabled
  logic const_en; // fixed period
  logic sense_skip; // skip sense low
  logic wait_skip; // skip pre wait
  logic [7:0] lim_chg; // charge limit
  logic [7:0] lim_low; // sense low limit
  logic [7:0] lim_dis; // discharge limit
  logic [7:0] lim_set; // settle limit
  logic [7:0] lim_wait; // wait limit
  logic [7:0] lim_post; // post limit

  // ****************************************
  // decode of loaded settings
  // ****************************************
  assign mj = sh_mode_q[tsq_pkg::MODE_MJ +: 3];
  assign pre_en = sh_mode_q[tsq_pkg::MODE_PRE];
  assign rnd_en = sh_mode_q[tsq_pkg::MODE_RND];
  assign const_en = sh_mode_q[tsq_pkg::MODE_CONST];
  assign sense_skip = sh_tcr_q[0][tsq_pkg::TCR0_SKIP];
  assign wait_skip = sh_tcr_q[2][tsq_pkg::TCR2_SKIP];
  // each limit is field value, period is limit plus one
  assign lim_chg = {1'b0, sh_tcr_q[0][6:0]};
  assign lim_low = {4'h0, sh_tcr_q[1][3:0]};
  assign lim_dis = {6'h00, sh_tcr_q[1][tsq_pkg::TCR1_DIS +: 2]};
  assign lim_set = {5'h00, sh_tcr_q[2][2:0]};
  assign lim_wait = {4'h0, sh_tcr_q[2][tsq_pkg::TCR2_WAIT +: 4]};
  assign lim_post = {4'h0, sh_tcr_q[3][3:0]};

  // ****************************************
  // main measurement timing
  // ****************************************
  // pick nibble of the current random store
  assign rv_cur = rv_idx_q[0] ? rv_q[rv_idx_q[3:1]][7:4]
                              : rv_q[rv_idx_q[3:1]][3:0];
  assign n_samp = {mj, 1'b1};
  assign win_lo = rnd_en ? {4'h0, rv_cur} : 8'h00;
  assign win_hi = 8'(win_lo + {4'h0, n_samp});
  // fixed period hides the random offset inside sixteen cycles
  always_comb
  begin
    if (rnd_en && const_en)
    begin
      main_len = (mj != 3'h0)
        ? 8'(tsq_pkg::MAIN_FIXED_CYC + {4'h0, n_samp})
        : tsq_pkg::MAIN_FIXED_CYC;
    end
    else
    begin
      main_len = win_hi;
    end
  end
  assign is_main = (state_q == tsq_pkg::ST_S1_MAIN) ||
                   (state_q == tsq_pkg::ST_S2_MAIN);
  assign is_judge = (state_q == tsq_pkg::ST_S1_JUDGE) ||
                    (state_q == tsq_pkg::ST_S2_JUDGE);
  assign in_win = is_main && (cnt_q >= win_lo) && (cnt_q < win_hi);
  // high when more than half of the samples were high
  assign main_hi = hi_cnt_q > {1'b0, mj};
  assign pre_cnt = pre_en && pre_hi_q;
  assign both_low = !main_hi && (!pre_en || !pre_hi_q);
  assign prim_nx = 9'(prim_q + {8'h00, pre_cnt} +
                      {8'h00, main_hi});

  // ****************************************
  // start source selection
  // ****************************************
  always_comb
  begin
    case (ctrl_q[tsq_pkg::CTRL_TRIG +: 2])
      tsq_pkg::TRIG_SW: go = start_q;
      tsq_pkg::TRIG_TMR: go = start_q && i_timer_trig;
      tsq_pkg::TRIG_EXT: go = start_q && ext_prev_q &&
                              !i_ext_trig;
      default: go = 1'b0; // reserved code never starts
    endcase
  end

  // ****************************************
  // status counter next state
  // ****************************************
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      tsq_pkg::ST_IDLE: if (go) state_d = tsq_pkg::ST_LOAD;
      tsq_pkg::ST_LOAD: state_d = tsq_pkg::ST_CHARGE;
      tsq_pkg::ST_CHARGE:
        if (cnt_q == lim_chg) state_d = tsq_pkg::ST_INIT;
      tsq_pkg::ST_INIT:
        state_d = sense_skip ? tsq_pkg::ST_S1_DIS
                             : tsq_pkg::ST_S1_LOW;
      tsq_pkg::ST_S1_LOW:
        if (cnt_q == lim_low) state_d = tsq_pkg::ST_S1_DIS;
      tsq_pkg::ST_S1_DIS:
        if (cnt_q == lim_dis) state_d = tsq_pkg::ST_S1_SET;
      tsq_pkg::ST_S1_SET:
        if (cnt_q == lim_set) state_d = tsq_pkg::ST_S1_DUM;
      tsq_pkg::ST_S1_DUM:
        state_d = wait_skip ? tsq_pkg::ST_S1_MAIN
                            : tsq_pkg::ST_S1_WAIT;
      tsq_pkg::ST_S1_WAIT:
        if (cnt_q == lim_wait) state_d = tsq_pkg::ST_S1_MAIN;
      tsq_pkg::ST_S1_MAIN:
        if (cnt_q == 8'(main_len - 8'h01))
          state_d = tsq_pkg::ST_S1_JUDGE;
      tsq_pkg::ST_S1_JUDGE: state_d = tsq_pkg::ST_S1_POST;
      tsq_pkg::ST_S1_POST:
        if (cnt_q == lim_post)
        begin
          // step two goes via the dummy, else repeat step one
          if (step2_q)
            state_d = tsq_pkg::ST_DUM12;
          else
            state_d = sense_skip ? tsq_pkg::ST_S1_DIS
                                 : tsq_pkg::ST_S1_LOW;
        end
      tsq_pkg::ST_DUM12:
        state_d = sense_skip ? tsq_pkg::ST_S2_DIS
                             : tsq_pkg::ST_S2_LOW;
      tsq_pkg::ST_S2_LOW:
        if (cnt_q == lim_low) state_d = tsq_pkg::ST_S2_DIS;
      tsq_pkg::ST_S2_DIS:
        if (cnt_q == lim_dis) state_d = tsq_pkg::ST_S2_SET;
      tsq_pkg::ST_S2_SET:
        if (cnt_q == lim_set) state_d = tsq_pkg::ST_S2_DUM;
      tsq_pkg::ST_S2_DUM:
        state_d = wait_skip ? tsq_pkg::ST_S2_MAIN
                            : tsq_pkg::ST_S2_WAIT;
      tsq_pkg::ST_S2_WAIT:
        if (cnt_q == lim_wait) state_d = tsq_pkg::ST_S2_MAIN;
      tsq_pkg::ST_S2_MAIN:
        if (cnt_q == 8'(main_len - 8'h01))
          state_d = tsq_pkg::ST_S2_JUDGE;
      tsq_pkg::ST_S2_JUDGE: state_d = tsq_pkg::ST_S2_POST;
      tsq_pkg::ST_S2_POST:
        if (cnt_q == lim_post)
        begin
          // only a zero secondary ends the channel
          if (sec_q == 5'h00)
            state_d = tsq_pkg::ST_XFER;
          else
            state_d = tsq_pkg::ST_S2_DIS;
        end
      tsq_pkg::ST_XFER: state_d = tsq_pkg::ST_GAP;
      tsq_pkg::ST_GAP: state_d = tsq_pkg::ST_CHAN;
      tsq_pkg::ST_CHAN:
        state_d = (chan_q != range_q) ? tsq_pkg::ST_LOAD
                                      : tsq_pkg::ST_WAIT_XFER;
      tsq_pkg::ST_WAIT_XFER:
        if (!xfer_pend_q) state_d = tsq_pkg::ST_IRQ;
      tsq_pkg::ST_IRQ: state_d = tsq_pkg::ST_IDLE;
      default: state_d = tsq_pkg::ST_IDLE;
    endcase
    // clearing the start bit stops the sequence at once
    if (!start_q) state_d = tsq_pkg::ST_IDLE;
  end

  // ****************************************
  // status register and period counter
  // ****************************************
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      state_q <= tsq_pkg::ST_IDLE;
      cnt_q <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      // period count restarts on every status change
      cnt_q <= (state_d != state_q) ? 8'h00 : 8'(cnt_q + 8'h01);
    end
  end

  // ****************************************
  // settings loaded at status 1
  // ****************************************
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      sh_mode_q <= tsq_pkg::REG_RST;
      sh_tcr_q <= '{default: tsq_pkg::REG_RST};
    end
    else if (state_q == tsq_pkg::ST_LOAD)
    begin
      sh_mode_q <= mode_q;
      sh_tcr_q <= tcr_q;
    end
  end

  // ****************************************
  // sampling of the sense pin
  // ****************************************
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      hi_cnt_q <= 4'h0;
      pre_hi_q <= 1'b0;
    end
    else
    begin
      // count highs inside the sample window
      if (is_main)
        hi_cnt_q <= 4'(hi_cnt_q + {3'h0, in_win && i_sense_in});
      else if (!is_judge)
        hi_cnt_q <= 4'h0;
      // pre takes one plain sample at the period start
      if (is_main && cnt_q == 8'h00)
        pre_hi_q <= i_sense_in;
    end
  end

  // ****************************************
  // primary and secondary counters, results
  // ****************************************
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      prim_q <= 9'h000;
      sec_q <= 5'h00;
      step2_q <= 1'b0;
      res1_q <= 9'h000;
      res2_q <= 9'h000;
    end
    else if (state_q == tsq_pkg::ST_LOAD)
    begin
      // fresh channel: counters and step start over
      prim_q <= 9'h000;
      sec_q <= 5'h00;
      step2_q <= 1'b0;
    end
    else if (state_q == tsq_pkg::ST_S1_JUDGE)
    begin
      prim_q <= prim_nx;
      if (both_low)
      begin
        step2_q <= 1'b1;
        res1_q <= prim_q;
        sec_q <= sstart_q;
      end
    end
    else if (state_q == tsq_pkg::ST_S2_JUDGE)
    begin
      prim_q <= prim_nx;
      // secondary follows main judgement only
      if (main_hi)
      begin
        if (sec_q != sstart_q) sec_q <= 5'(sec_q + 5'h01);
      end
      else if (sec_q != 5'h00)
      begin
        sec_q <= 5'(sec_q - 5'h01);
      end
    end
    else if (state_q == tsq_pkg::ST_S2_POST && sec_q == 5'h00)
    begin
      // primary is frozen after the zero was reached
      res2_q <= prim_q;
    end
  end

  // ****************************************
  // random index, channel, short switch
  // ****************************************
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      rv_idx_q <= 4'h0;
      chan_q <= 3'h0;
      short_q <= 1'b0;
    end
    else
    begin
      // one step per main measurement, wraps at sixteen
      if (is_judge && rnd_en)
        rv_idx_q <= 4'(rv_idx_q + 4'h1);
      if (state_q == tsq_pkg::ST_IDLE)
        chan_q <= 3'h0;
      else if (state_q == tsq_pkg::ST_CHAN && chan_q != range_q)
        chan_q <= 3'(chan_q + 3'h1);
      if ((state_q == tsq_pkg::ST_S1_SET ||
           state_q == tsq_pkg::ST_S2_SET) &&
          ctrl_q[tsq_pkg::CTRL_SHORT])
        short_q <= 1'b1;
      else if ((state_q == tsq_pkg::ST_S1_POST ||
                state_q == tsq_pkg::ST_S2_POST) &&
               ctrl_q[tsq_pkg::CTRL_SHORT])
        short_q <= 1'b0;
    end
  end

  // ****************************************
  // pin drive, registered from next status
  // ****************************************
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      o_charge_oe <= 1'b0;
      o_charge_out <= 1'b0;
      o_sense_oe <= 1'b0;
      o_sense_out <= 1'b0;
      o_bias_oe <= 1'b0;
      o_bias_out <= 1'b0;
    end
    else
    begin
      // all other statuses leave every pin floating
      o_charge_oe <= state_d == tsq_pkg::ST_CHARGE;
      o_charge_out <= state_d == tsq_pkg::ST_CHARGE;
      o_sense_oe <= state_d == tsq_pkg::ST_S1_LOW ||
                    state_d == tsq_pkg::ST_S2_LOW ||
                    state_d == tsq_pkg::ST_S1_DIS ||
                    state_d == tsq_pkg::ST_S2_DIS;
      o_sense_out <= 1'b0;
      o_bias_oe <= state_d == tsq_pkg::ST_S1_DIS ||
                   state_d == tsq_pkg::ST_S2_DIS;
      o_bias_out <= 1'b0;
    end
  end

  // ****************************************
  // transfer request, interrupt, status view
  // ****************************************
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      o_xfer_req <= 1'b0;
      xfer_pend_q <= 1'b0;
      o_irq <= 1'b0;
      o_status <= 5'h00;
      ext_prev_q <= 1'b0;
    end
    else
    begin
      o_xfer_req <= state_d == tsq_pkg::ST_XFER;
      // a new request wins over a done in the same cycle
      if (state_q == tsq_pkg::ST_XFER)
        xfer_pend_q <= 1'b1;
      else if (i_xfer_done)
        xfer_pend_q <= 1'b0;
      o_irq <= state_d == tsq_pkg::ST_IRQ;
      o_status <= 5'(state_d);
      ext_prev_q <= i_ext_trig;
    end
  end
  assign o_bc_short = short_q;
  assign o_channel = chan_q;

  // ****************************************
  // writable registers
  // ****************************************
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      start_q <= 1'b0;
      ctrl_q <= tsq_pkg::REG_RST;
      mode_q <= tsq_pkg::REG_RST;
      tcr_q <= '{default: tsq_pkg::REG_RST};
      range_q <= 3'h0;
      sstart_q <= 5'h00;
    end
    else
    begin
      // software write beats the end-of-run clear
      if (i_wr && i_addr == tsq_pkg::ADDR_CTRL)
        start_q <= i_wdata[tsq_pkg::CTRL_START];
      else if (state_q == tsq_pkg::ST_IRQ)
        start_q <= 1'b0;
      if (i_wr)
      begin
        case (i_addr)
          tsq_pkg::ADDR_CTRL: ctrl_q <= i_wdata;
          tsq_pkg::ADDR_MODE: mode_q <= i_wdata;
          tsq_pkg::ADDR_TCR0: tcr_q[0] <= i_wdata;
          tsq_pkg::ADDR_TCR1: tcr_q[1] <= i_wdata;
          tsq_pkg::ADDR_TCR2: tcr_q[2] <= i_wdata;
          tsq_pkg::ADDR_TCR3: tcr_q[3] <= i_wdata;
          tsq_pkg::ADDR_CHAN: range_q <= i_wdata[2:0];
          tsq_pkg::ADDR_SSTART: sstart_q <= i_wdata[4:0];
          default: ; // random stores are written below, other offsets hold no writable state
        endcase
      end
    end
  end

  // random stores, one byte each
  for (genvar g = 0; g < 8; g++)
  begin : g_rv
    always_ff @(posedge i_mclk)
    begin
      if (!i_rst_b)
        rv_q[g] <= tsq_pkg::REG_RST;
      else if (i_wr && i_addr == 5'(tsq_pkg::ADDR_RV0 + 5'(g)))
        rv_q[g] <= i_wdata;
    end
  end

  // ****************************************
  // read data, one cycle after the strobe
  // ****************************************
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
      o_rdata <= 8'h00;
    else if (i_rd)
    begin
      if (i_addr[4:3] == 2'h1)
        o_rdata <= rv_q[i_addr[2:0]];
      else
      begin
        case (i_addr)
          tsq_pkg::ADDR_CTRL: o_rdata <= {ctrl_q[7:1], start_q};
          tsq_pkg::ADDR_MODE: o_rdata <= mode_q;
          tsq_pkg::ADDR_TCR0: o_rdata <= tcr_q[0];
          tsq_pkg::ADDR_TCR1: o_rdata <= tcr_q[1];
          tsq_pkg::ADDR_TCR2: o_rdata <= tcr_q[2];
          tsq_pkg::ADDR_TCR3: o_rdata <= tcr_q[3];
          tsq_pkg::ADDR_CHAN: o_rdata <= {5'h00, range_q};
          tsq_pkg::ADDR_SSTART: o_rdata <= {3'h0, sstart_q};
          tsq_pkg::ADDR_RES1_LO: o_rdata <= res1_q[7:0];
          tsq_pkg::ADDR_RES1_HI: o_rdata <= {7'h00, res1_q[8]};
          tsq_pkg::ADDR_PRIM_LO: o_rdata <= res2_q[7:0];
          tsq_pkg::ADDR_PRIM_HI: o_rdata <= {7'h00, res2_q[8]};
          tsq_pkg::ADDR_STAT: o_rdata <= {chan_q, 5'(state_q)};
          tsq_pkg::ADDR_SEC: o_rdata <= {3'h0, sec_q};
          default: o_rdata <= 8'h00; // unmapped reads zero
        endcase
      end
    end
    else
      o_rdata <= 8'h00;
  end
endmodule
`default_nettype wire

// file: sim/tsq_sequencer_chk.sv
// assertions on the sequencer's pins and status
`timescale 1ns/1ps
`default_nettype none
module tsq_sequencer_chk (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // watched outputs
  input wire logic [4:0] o_status,
  input wire logic o_sense_oe,
  input wire logic o_bias_oe,
  input wire logic o_charge_oe,
  input wire logic o_charge_out,
  input wire logic o_xfer_req,
  input wire logic o_irq
);
  // ***
  // checks
  // ***
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  // interrupt status, then idle with the pulse gone
  sequence s_irq_end;
    (o_status == 5'd25) ##1 (o_status == 5'd0 && !o_irq);
  endsequence
  a_idle_pins_off: assert property (o_status <= 5'd1 |->
    !(o_sense_oe || o_bias_oe || o_charge_oe)) else $error("idle pins");
  a_load_next: assert property (o_status == 5'd1 |=> o_status == 5'd2)
    else $error("load step");
  a_charge_drive: assert property ((o_status == 5'd2) ==
    (o_charge_oe && o_charge_out)) else $error("charge drive");
  a_sense_low: assert property (o_status inside {5'd4, 5'd13} |->
    o_sense_oe && !o_bias_oe) else $error("sense low");
  a_dis_both: assert property ((o_status inside {5'd5, 5'd14}) ==
    (o_bias_oe && o_sense_oe)) else $error("discharge");
  a_judge_next: assert property (o_status == 5'd19 |=> o_status == 5'd20)
    else $error("judge order");
  a_zero_test: assert property (o_status == 5'd20 |=>
    o_status inside {5'd14, 5'd20, 5'd21}) else $error("zero test");
  a_xfer_pulse: assert property (o_xfer_req |->
    o_status == 5'd21 ##1 !o_xfer_req) else $error("xfer pulse");
  a_chan_branch: assert property (o_status == 5'd23 |=>
    o_status inside {5'd1, 5'd24}) else $error("channel branch");
  a_irq_end: assert property (o_irq |-> s_irq_end)
    else $error("irq pulse");
endmodule
bind tsq_sequencer tsq_sequencer_chk u_chk (.i_mclk, .i_rst_b, .o_status,
  .o_sense_oe, .o_bias_oe, .o_charge_oe, .o_charge_out, .o_xfer_req, .o_irq);
`default_nettype wire

// file: sim/tsq_electrode.sv
// electrode and reference capacitor seen at the pins
`timescale 1ns/1ps
`default_nettype none
module tsq_electrode (
  // drive from the sequencer
  input wire logic i_mclk,
  input wire logic i_sense_oe,
  input wire logic i_bias_oe,
  input wire logic i_charge_oe,
  // discharges after which the sense pin reads low
  input wire logic [3:0] i_highs,
  // level at the sense pin
  output logic o_sense
);
  logic [3:0] chg_q; // charge left, in discharge steps
  logic dis_q; // bias drive one cycle ago
  // charging fills, each discharge burst drains one step
  always @(posedge i_mclk)
  begin
    dis_q <= i_bias_oe;
    if (i_charge_oe)
      chg_q <= i_highs;
    else if (i_bias_oe && !dis_q && chg_q != 4'h0)
      chg_q <= chg_q - 4'h1;
  end
  // a pin driven low reads low, else the capacitor level
  assign o_sense = i_sense_oe ? 1'b0 : (chg_q != 4'h0);
endmodule
`default_nettype wire

// file: sim/touch_sense_sequencer_tb.sv
// self-checking bench for the touch sense sequencer
`timescale 1ns/1ps
`default_nettype none
module touch_sense_sequencer_tb;
  // ***
  // signals
  // ***
  logic i_mclk, i_rst_b, i_wr, i_rd, i_timer_trig, i_ext_trig, i_xfer_done;
  logic [4:0] i_addr, o_status;
  logic [7:0] i_wdata, o_rdata;
  logic [2:0] o_channel;
  logic o_sense_out, o_sense_oe, o_bias_out, o_bias_oe, o_charge_out;
  logic o_charge_oe, o_bc_short, o_xfer_req, o_irq, sense_w, short_v;
  logic [3:0] highs, xfer_q;
  int fail_count, comparisons, seed, chg_n, main_n, main_len;
  tsq_sequencer u_dut (.i_mclk, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_timer_trig, .i_ext_trig, .i_sense_in(sense_w), .o_sense_out,
    .o_sense_oe, .o_bias_out, .o_bias_oe, .o_charge_out, .o_charge_oe,
    .o_bc_short, .o_xfer_req, .i_xfer_done, .o_irq, .o_status, .o_channel);
  tsq_electrode u_elec (.i_mclk, .i_sense_oe(o_sense_oe),
    .i_bias_oe(o_bias_oe), .i_charge_oe(o_charge_oe), .i_highs(highs),
    .o_sense(sense_w));
  // 50 MHz clock
  initial
  begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  // transfer engine finishes five cycles after a request
  always @(posedge i_mclk)
  begin
    xfer_q <= {xfer_q[2:0], o_xfer_req};
    i_xfer_done <= xfer_q[3];
  end
  // lengths of the charge drive and of the last step-one main period
  always @(posedge i_mclk)
  begin
    chg_n <= (o_status == 5'd1) ? 0 : chg_n + int'(o_charge_oe);
    main_n <= (o_status == 5'd9) ? main_n + 1 : 0;
    if (o_status == 5'd10)
      main_len <= main_n;
    if (o_status == 5'd9) short_v <= o_bc_short;
  end
  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want)
    begin
      fail_count++;
      $display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
    end
  endtask
  // one-cycle register write
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  // read; data stands in the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  // primary count at the first low judgement
  function automatic logic [15:0] exp_res(input logic pre, input logic [3:0] k);
    return (pre ? 16'd2 : 16'd1) * 16'(k - 4'd1);
  endfunction
  // main period length from random, fixed and majority settings
  function automatic int exp_main(input logic rnd, cst,
    input logic [2:0] mj, input logic [3:0] w);
    return (rnd && cst) ? 16 + (mj == 3'd0 ? 0 : 2 * mj + 1)
      : (rnd ? int'(w) : 0) + 2 * mj + 1;
  endfunction
  // one full run under the given start source
  task automatic run_one(input logic [1:0] trig);
    logic [6:0] chg;
    logic [2:0] mj;
    logic pre, rnd, sh, cst;
    logic [7:0] d, h;
    logic [3:0] w;
    int n;
    chg = 7'($random(seed));
    mj = 3'($random(seed));
    {pre, rnd, sh, cst} = 4'($random(seed));
    highs = 4'd1 + 4'($random(seed) & 7);
    w = 4'($random(seed));
    wr(tsq_pkg::ADDR_MODE, {1'b0, mj, 1'b0, cst, rnd, pre});
    wr(tsq_pkg::ADDR_TCR0, {1'($random(seed)), chg});
    // every random store holds w, so each main offset is w
    for (int r = 3; r < 16; r++)
      wr(5'(r), r < 8 ? 8'($random(seed)) : {w, w});
    h = 8'($random(seed) & 1);
    wr(tsq_pkg::ADDR_CHAN, h);
    wr(tsq_pkg::ADDR_SSTART, 8'($random(seed) & 31));
    wr(tsq_pkg::ADDR_CTRL, {4'd0, trig, sh, 1'b1});
    if (trig != tsq_pkg::TRIG_SW)
    begin
      repeat (2) @(posedge i_mclk);
      #1 check(16'(o_status), 16'd0);
      @(posedge i_mclk);
      i_timer_trig <= (trig == tsq_pkg::TRIG_TMR);
      i_ext_trig <= (trig != tsq_pkg::TRIG_EXT);
      @(posedge i_mclk);
      {i_timer_trig, i_ext_trig} <= 2'b01;
    end
    n = 0;
    while (o_irq !== 1'b1 && n < 20000)
    begin
      @(posedge i_mclk);
      #1 n++;
    end
    check(16'(n < 20000), 16'd1);
    check(16'(o_channel), 16'(h));
    check(16'(short_v), 16'(sh));
    check(16'({o_bc_short, o_sense_out, o_bias_out}), 16'd0);
    rd(tsq_pkg::ADDR_RES1_LO, d);
    rd(tsq_pkg::ADDR_RES1_HI, h);
    check({h, d}, exp_res(pre, highs));
    rd(tsq_pkg::ADDR_PRIM_LO, d);
    rd(tsq_pkg::ADDR_PRIM_HI, h);
    check({h, d}, exp_res(pre, highs));
    rd(tsq_pkg::ADDR_SEC, d);
    check(16'(d), 16'd0);
    rd(tsq_pkg::ADDR_CTRL, d);
    check(16'(d), 16'({trig, sh, 1'b0}));
    check(16'(chg_n), 16'(chg) + 16'd1);
    check(16'(main_len), 16'(exp_main(rnd, cst, mj, w)));
  endtask
  // counts, verdict and end of run
  task automatic print_verdict();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // cut a hang short
  initial
  begin
    #2000000;
    fail_count++;
    print_verdict();
  end
  // reset, register checks, runs under every start source
  initial
  begin
    logic [7:0] d;
    seed = 32'h239d;
    {i_rst_b, i_wr, i_rd, i_timer_trig} = 4'd0;
    {i_addr, i_wdata, highs} = 17'd0;
    i_ext_trig = 1'b1;
    repeat (3) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    rd(tsq_pkg::ADDR_MODE, d);
    check(16'(d), 16'(tsq_pkg::REG_RST));
    rd(5'h1f, d);
    check(16'(d), 16'd0);
    for (int t = 0; t < 6; t++)
      run_one(t % 3 == 0 ? tsq_pkg::TRIG_SW :
        (t % 3 == 1 ? tsq_pkg::TRIG_TMR : tsq_pkg::TRIG_EXT));
    print_verdict();
  end
endmodule
`default_nettype wire
